// *** tec16_timer.sv ***
// 16-bit timer/event counter channel with Avalon-MM register access
`timescale 1ns/10ps
`default_nettype none
module tec16_timer
  import tec16_pkg::*;
#(
  parameter int DIV0 = DIV_SEL0,
  parameter int DIV1 = DIV_SEL1,
  parameter int DIV2 = DIV_SEL2
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire tec16_pkg::tec16_avs_req_t avs_req,
  output logic                      avs_waitrequest,
  output logic [tec16_pkg::DATA_W-1:0] avs_readdata,
  input  wire logic                 edge_input_a,
  input  wire logic                 edge_input_b,
  output logic                      timer_output,
  output logic                      timer_output_oe
);
  import tec16_pkg::*;

  // ==========================================================
  // Storage
  tec16_ctrl_t          ctrl_reg;
  logic [CNT_W-1:0]     period_compare_reg;
  logic [CNT_W-1:0]     duty_compare_reg;
  logic [CNT_W-1:0]     count_value_reg;
  logic [CNT_W-1:0]     cap_a_reg;
  logic [CNT_W-1:0]     cap_b_reg;
  logic                 oneshot_trigger_bit_reg;
  logic                 out_reg;
  logic                 ack_reg;
  logic [DATA_W-1:0]    rdata_reg;
  tec16_os_state_t      os_state_reg;
  tec16_os_state_t      os_state_next;

  // ==========================================================
  // Decoded controls
  logic        run;
  logic [1:0]  clk_sel;
  logic        div_tick;
  logic        cnt_tick;
  logic        ea_pulse;
  logic        eb_pulse;
  logic        req;
  logic        wr_ok;
  logic        period_hit;
  logic        duty_hit;
  logic        os_trig;
  logic        os_start;
  logic        cmp_clear;
  logic        edge_clear;
  logic [DATA_W-1:0] rd_mux;

  assign run     = ctrl_reg.enable;
  assign clk_sel = {ctrl_reg.count_clock_sel_hi, ctrl_reg.count_clock_sel_lo};

  // ==========================================================
  // Avalon-MM slave: one wait cycle per access
  assign req             = avs_req.read || avs_req.write;
  assign avs_waitrequest = req && !ack_reg;
  assign wr_ok           = avs_req.write && ack_reg;
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  function automatic logic [DATA_W-1:0] be_merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0]        be
  );
    logic [DATA_W-1:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Merged write words, sliced to register width below
  logic [DATA_W-1:0] ctrl_wr;
  logic [DATA_W-1:0] period_wr;
  logic [DATA_W-1:0] duty_wr;
  assign ctrl_wr   = be_merge(DATA_W'(ctrl_reg), avs_req.writedata, avs_req.byteenable);
  assign period_wr = be_merge(DATA_W'(period_compare_reg), avs_req.writedata, avs_req.byteenable);
  assign duty_wr   = be_merge(DATA_W'(duty_compare_reg), avs_req.writedata, avs_req.byteenable);

  // ==========================================================
  // Software-written registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= tec16_ctrl_t'(CTRL_RST);
    end else if (wr_ok && avs_req.address == OFS_CTRL) begin
      ctrl_reg <= tec16_ctrl_t'(ctrl_wr[$bits(tec16_ctrl_t)-1:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_compare_reg <= PERIOD_RST;
    end else if (wr_ok && avs_req.address == OFS_PERIOD) begin
      period_compare_reg <= period_wr[CNT_W-1:0];
    end
  end

  // Duty may be rewritten while counting; takes effect on the next compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_compare_reg <= DUTY_RST;
    end else if (wr_ok && avs_req.address == OFS_DUTY) begin
      duty_compare_reg <= duty_wr[CNT_W-1:0];
    end
  end

  // Self-clearing trigger, lives one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oneshot_trigger_bit_reg <= 1'b0;
    end else begin
      oneshot_trigger_bit_reg <= wr_ok && avs_req.address == OFS_TRIG &&
                                 avs_req.byteenable[0] && avs_req.writedata[TRIG_BIT];
    end
  end

  // ==========================================================
  // Count clock and edge inputs
  tec16_presc #(
    .DIV0 (DIV0),
    .DIV1 (DIV1),
    .DIV2 (DIV2)
  ) u_presc (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (run),
    .sel   (clk_sel),
    .tick  (div_tick)
  );

  tec16_edge u_edge_a (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (run),
    .pin   (edge_input_a),
    .sel   (ctrl_reg.edge_a_sel),
    .pulse (ea_pulse)
  );

  tec16_edge u_edge_b (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (run),
    .pin   (edge_input_b),
    .sel   (ctrl_reg.edge_b_sel),
    .pulse (eb_pulse)
  );

  assign cnt_tick = (clk_sel == CLK_SEL_EDGE_A) ? ea_pulse : div_tick;

  // ==========================================================
  // Counter
  assign period_hit = count_value_reg == period_compare_reg;
  assign duty_hit   = count_value_reg == duty_compare_reg;
  assign cmp_clear  = cnt_tick && period_hit &&
                      (ctrl_reg.mode == MODE_CMP_CLR || ctrl_reg.mode == MODE_PPG ||
                       ctrl_reg.oneshot);
  assign edge_clear = ctrl_reg.mode == MODE_EDGE_CLR && ea_pulse;

  assign os_trig  = oneshot_trigger_bit_reg || (ctrl_reg.ext_trig_en && ea_pulse);
  assign os_start = run && ctrl_reg.oneshot && os_state_reg == OS_IDLE && os_trig;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_reg <= '0;
    end else if (!run) begin
      count_value_reg <= '0;
    end else if (edge_clear || os_start) begin
      count_value_reg <= '0;
    end else if (cmp_clear) begin
      count_value_reg <= '0;
    end else if (cnt_tick) begin
      count_value_reg <= count_value_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Capture
  // Capture registers hold their value across a stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_a_reg <= '0;
    end else if (ctrl_reg.cap_a_en && ea_pulse) begin
      cap_a_reg <= count_value_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_b_reg <= '0;
    end else if (ctrl_reg.cap_b_en && eb_pulse) begin
      cap_b_reg <= count_value_reg;
    end
  end

  // ==========================================================
  // One-shot sequencer
  // Triggers during a pulse are ignored rather than restarting it
  always_comb begin
    os_state_next = os_state_reg;
    case (os_state_reg)
      OS_IDLE: begin
        if (os_start) begin
          os_state_next = OS_WAIT;
        end
      end
      OS_WAIT: begin
        if (cnt_tick && duty_hit) begin
          os_state_next = OS_HIGH;
        end
      end
      OS_HIGH: begin
        if (cnt_tick && period_hit) begin
          os_state_next = OS_IDLE;
        end
      end
      default: begin
        os_state_next = OS_IDLE;
      end
    endcase
    if (!run || !ctrl_reg.oneshot) begin
      os_state_next = OS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      os_state_reg <= OS_IDLE;
    end else begin
      os_state_reg <= os_state_next;
    end
  end

  // ==========================================================
  // Timer output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (!run) begin
      out_reg <= 1'b0;
    end else if (ctrl_reg.oneshot) begin
      out_reg <= os_state_next == OS_HIGH;
    end else if (ctrl_reg.mode == MODE_PPG && cnt_tick && (period_hit || duty_hit)) begin
      out_reg <= !out_reg;
    end
  end

  // Output enable lets the shared pin fall back to its other use
  assign timer_output    = out_reg && ctrl_reg.out_en;
  assign timer_output_oe = ctrl_reg.out_en;

  // ==========================================================
  // Read-back
  always_comb begin
    case (avs_req.address)
      OFS_CTRL:   rd_mux = DATA_W'(ctrl_reg);
      OFS_PERIOD: rd_mux = DATA_W'(period_compare_reg);
      OFS_DUTY:   rd_mux = DATA_W'(duty_compare_reg);
      OFS_COUNT:  rd_mux = DATA_W'(count_value_reg);
      OFS_CAP_A:  rd_mux = DATA_W'(cap_a_reg);
      OFS_CAP_B:  rd_mux = DATA_W'(cap_b_reg);
      OFS_STATUS: rd_mux = DATA_W'({os_state_reg != OS_IDLE, out_reg});
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (avs_req.read && !ack_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // ==========================================================
  // Checks
  chk_edge_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
    run && ctrl_reg.mode == MODE_EDGE_CLR && ea_pulse && !wr_ok |=> count_value_reg == '0)
    else $error("Edge clear did not zero the counter");

  chk_oneshot_start: assert property (@(posedge clk) disable iff (!rst_n)
    os_start && !wr_ok |=> os_state_reg == OS_WAIT && count_value_reg == '0 && !out_reg)
    else $error("One-shot trigger did not start a pulse");

  chk_trig_bit_start: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ok && avs_req.address == OFS_TRIG && avs_req.writedata[TRIG_BIT] &&
    avs_req.byteenable[0] && run && ctrl_reg.oneshot && os_state_reg == OS_IDLE &&
    !cnt_tick ##1 run && ctrl_reg.oneshot |=> os_state_reg == OS_WAIT)
    else $error("Trigger bit write ignored");

  chk_ppg_period: assert property (@(posedge clk) disable iff (!rst_n)
    run && !ctrl_reg.oneshot && ctrl_reg.mode == MODE_PPG && cnt_tick && period_hit &&
    !edge_clear && !wr_ok |=> count_value_reg == '0 && out_reg != $past(out_reg))
    else $error("PPG period match did not clear and toggle");

  chk_ppg_duty: assert property (@(posedge clk) disable iff (!rst_n)
    run && !ctrl_reg.oneshot && ctrl_reg.mode == MODE_PPG && cnt_tick && duty_hit &&
    !period_hit && !wr_ok |=> out_reg != $past(out_reg))
    else $error("PPG duty match did not toggle output");

  cov_ppg_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg.mode == MODE_PPG && run && $rose(out_reg));
  cov_oneshot_done: cover property (@(posedge clk) disable iff (!rst_n)
    os_state_reg == OS_HIGH ##1 os_state_reg == OS_IDLE);
  cov_capture_b: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg.cap_b_en && eb_pulse);
endmodule
`default_nettype wire

// *** tec16_pkg.sv ***
// Shared constants, types and register map of the 16-bit timer/event counter
package tec16_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TRIG   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP_A  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_CAP_B  = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h1C;

  // ==========================================================
  // Reset values and field positions outside the control struct
  localparam logic [13:0]      CTRL_RST   = 14'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] DUTY_RST   = 16'h0000;
  localparam int               TRIG_BIT   = 0;

  // ==========================================================
  // Count clock selection and prescaler ratios
  localparam logic [1:0] CLK_SEL_EDGE_A = 2'h3;
  localparam int         DIV_SEL0       = 2;
  localparam int         DIV_SEL1       = 8;
  localparam int         DIV_SEL2       = 32;

  // ==========================================================
  // Valid edge selection
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [1:0] {
    MODE_FREE,
    MODE_CMP_CLR,
    MODE_EDGE_CLR,
    MODE_PPG
  } tec16_mode_t;

  typedef enum logic [1:0] {
    OS_IDLE,
    OS_WAIT,
    OS_HIGH
  } tec16_os_state_t;

  typedef struct packed {
    logic        ext_trig_en;
    logic        cap_b_en;
    logic        cap_a_en;
    logic [1:0]  edge_b_sel;
    logic [1:0]  edge_a_sel;
    logic        count_clock_sel_hi;
    logic        count_clock_sel_lo;
    logic        out_en;
    logic        oneshot;
    tec16_mode_t mode;
    logic        enable;
  } tec16_ctrl_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } tec16_avs_req_t;

endpackage

// *** tec16_presc.sv ***
// Prescaler producing one-cycle count enables
`timescale 1ns/10ps
`default_nettype none
module tec16_presc #(
  parameter int DIV0 = 2,
  parameter int DIV1 = 8,
  parameter int DIV2 = 32
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [7:0] div_reg;
  logic [7:0] lim;

  always_comb begin
    case (sel)
      2'h0:    lim = 8'(DIV0 - 1);
      2'h1:    lim = 8'(DIV1 - 1);
      2'h2:    lim = 8'(DIV2 - 1);
      default: lim = 8'h00;
    endcase
  end

  // Held at zero while stopped so the first tick comes a full period after start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
    end else if (!run || div_reg >= lim) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign tick = run && (sel != 2'h3) && (div_reg >= lim);
endmodule
`default_nettype wire

// *** tec16_edge.sv ***
// Valid-edge detector for one timer input pin
`timescale 1ns/10ps
`default_nettype none
module tec16_edge
  import tec16_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  output logic            pulse
);
  logic prev_reg;
  logic armed_reg;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg  <= (run || armed_reg) ? pin : 1'b0;
      armed_reg <= armed_reg | run;
    end
  end

  assign rise  = pin && !prev_reg;
  assign fall  = !pin && prev_reg;
  assign pulse = run && ((rise && (sel == EDGE_RISE || sel == EDGE_BOTH)) ||
                         (fall && (sel == EDGE_FALL || sel == EDGE_BOTH)));

  // ==========================================================
  // Checks
  chk_first_high_rise: assert property (@(posedge clk) disable iff (!rst_n)
    run && !armed_reg && pin && (sel == EDGE_RISE || sel == EDGE_BOTH) |-> pulse)
    else $error("High pin at first enable not seen as rising edge");

  chk_reenable_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    run && !$past(run) && $past(armed_reg) && $past(pin) && pin |-> !pulse)
    else $error("Spurious rising edge at re-enable");

  cov_first_rise: cover property (@(posedge clk) disable iff (!rst_n)
    run && !armed_reg && pin && pulse);
endmodule
`default_nettype wire

// *** tec16_pins_model.sv ***
// Model of the external pulse sources and the shared timer pin
`timescale 1ns/10ps
`default_nettype none
module tec16_pins_model (
  input  wire logic clk,
  input  wire logic timer_output,
  input  wire logic timer_output_oe,
  output logic      edge_input_a,
  output logic      edge_input_b
);
  logic a_lvl = 1'b0;
  logic b_lvl = 1'b0;

  assign edge_input_a = a_lvl;
  assign edge_input_b = timer_output_oe ? timer_output : b_lvl;

  // ==========================================================
  // Source stays synchronous to clk, as the edge detector expects
  task automatic drive_a(input logic v, input int hold);
    @(posedge clk);
    a_lvl <= v;
    repeat (hold) @(posedge clk);
  endtask

  // Capture source b, only meaningful while the timer output enable is off
  task automatic drive_b(input logic v, input int hold);
    @(posedge clk);
    b_lvl <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** tec16_timer_tb.sv ***
// Self-checking bench for the 16-bit timer/event counter
`timescale 1ns/10ps
`default_nettype none
module tec16_timer_tb;
  import tec16_pkg::*;
  logic              clk;
  logic              rst_n;
  tec16_avs_req_t    avs_req;
  logic              avs_waitrequest;
  logic [DATA_W-1:0] avs_readdata;
  logic              edge_input_a;
  logic              edge_input_b;
  logic              timer_output;
  logic              timer_output_oe;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] mon_exp;
  tec16_ctrl_t       ctrl;
  int                failures;
  int                n_tests;
  int                per;
  int                duty;
  int                w;
  int                h;
  int                l;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  tec16_timer dut_u (
    .clk             (clk),
    .rst_n           (rst_n),
    .avs_req         (avs_req),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .edge_input_a    (edge_input_a),
    .edge_input_b    (edge_input_b),
    .timer_output    (timer_output),
    .timer_output_oe (timer_output_oe)
  );

  tec16_pins_model pins_u (
    .clk             (clk),
    .timer_output    (timer_output),
    .timer_output_oe (timer_output_oe),
    .edge_input_a    (edge_input_a),
    .edge_input_b    (edge_input_b)
  );

  // ==========================================================
  // Reporting
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("wrong value %s expected %0h seen %0h", what, e, s);
      failures++;
    end
  endtask

  // ==========================================================
  // Avalon master: waitrequest sampled at the rising edge that takes the request
  task automatic bus_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    i = 0;
    @(posedge clk);
    avs_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      i++;
      if (i > 20) begin
        failures++;
        give_verdict();
      end
      @(posedge clk);
    end
    avs_req <= '0;
  endtask

  task automatic bus_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    bus_op(1'b0, a, 32'h0);
  endtask

  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_op(1'b1, a, d);
  endtask

  // Counts cycles until the output pin shows v
  task automatic wait_out(input logic v, output int n);
    n = 0;
    while (timer_output !== v) begin
      @(negedge clk);
      n++;
      if (n > 1000) begin
        failures++;
        give_verdict();
      end
    end
  endtask

  // ==========================================================
  // Read monitor: oldest note against the answered read
  always @(posedge clk) begin
    if (avs_req.read && avs_waitrequest === 1'b0) begin
      n_tests++;
      if (exp_q.size() == 0) begin
        $display("wrong value readdata expected none seen %0h", avs_readdata);
        failures++;
      end else begin
        mon_exp = exp_q.pop_front();
        if (avs_readdata !== mon_exp) begin
          $display("wrong value readdata expected %0h seen %0h", mon_exp, avs_readdata);
          failures++;
        end
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    avs_req = '0;
    rst_n = 1'b0;
    void'($urandom(23));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 8; k++)
      bus_read(5'(k * 4), (k == 2) ? 32'h0000FFFF : 32'h0);
    bus_write(OFS_COUNT, 32'h00001234);
    bus_read(OFS_COUNT, 32'h0);
    per = 8 + $urandom % 8;
    duty = 1 + $urandom % (per - 2);
    bus_write(OFS_PERIOD, 32'(per));
    bus_write(OFS_DUTY, 32'(duty));
    bus_read(OFS_PERIOD, 32'(per));
    bus_read(OFS_DUTY, 32'(duty));
    // Edge count clock, exercised here in free-running mode
    pins_u.drive_a(1'b1, 2);
    ctrl = '0;
    ctrl.enable = 1'b1;
    ctrl.count_clock_sel_hi = 1'b1;
    ctrl.count_clock_sel_lo = 1'b1;
    ctrl.edge_a_sel = EDGE_RISE;
    bus_write(OFS_CTRL, {18'h0, ctrl});
    repeat (3) @(posedge clk);
    bus_read(OFS_COUNT, 32'h1);
    bus_write(OFS_CTRL, 32'h0);
    bus_write(OFS_CTRL, {18'h0, ctrl});
    repeat (3) @(posedge clk);
    bus_read(OFS_COUNT, 32'h0);
    for (int k = 0; k < 3; k++) begin
      pins_u.drive_a(1'b0, 2);
      pins_u.drive_a(1'b1, 2);
    end
    bus_read(OFS_COUNT, 32'h3);
    bus_write(OFS_CTRL, 32'h0);
    pins_u.drive_a(1'b0, 1);
    ctrl = '0;
    ctrl.enable = 1'b1;
    ctrl.mode = MODE_PPG;
    ctrl.out_en = 1'b1;
    bus_write(OFS_CTRL, {18'h0, ctrl});
    @(posedge clk);
    check("output enable", 32'h1, 32'(timer_output_oe));
    for (int k = 0; k < 2; k++) begin
      wait_out(1'b0, w);
      // Rewrite just after the period match, while count is below the new duty
      if (k == 1) begin
        duty = per / 2;
        bus_write(OFS_DUTY, 32'(duty));
      end
      wait_out(1'b1, w);
      wait_out(1'b0, h);
      wait_out(1'b1, l);
      check("ppg period", 32'((per + 1) * DIV_SEL0), 32'(h + l));
      check("ppg high time", 32'((per - duty) * DIV_SEL0), 32'(h));
    end
    wait_out(1'b0, w);
    bus_write(OFS_CTRL, 32'h0);
    ctrl = '0;
    ctrl.enable = 1'b1;
    ctrl.mode = MODE_CMP_CLR;
    ctrl.oneshot = 1'b1;
    ctrl.out_en = 1'b1;
    ctrl.ext_trig_en = 1'b1;
    ctrl.edge_a_sel = EDGE_RISE;
    bus_write(OFS_CTRL, {18'h0, ctrl});
    for (int k = 0; k < 2; k++) begin
      wait_out(1'b0, w);
      if (k == 0)
        bus_write(OFS_TRIG, 32'h1);
      else
        pins_u.drive_a(1'b1, 1);
      wait_out(1'b1, w);
      wait_out(1'b0, h);
      check("pulse width", 32'((per - duty) * DIV_SEL0), 32'(h));
      repeat (4) @(posedge clk);
      pins_u.drive_a(1'b0, 1);
    end
    // Edge clear, then capture on input b with the output pin released
    bus_write(OFS_CTRL, 32'h0);
    ctrl = '0;
    ctrl.enable = 1'b1;
    ctrl.mode = MODE_EDGE_CLR;
    ctrl.edge_a_sel = EDGE_RISE;
    ctrl.edge_b_sel = EDGE_RISE;
    ctrl.cap_b_en = 1'b1;
    bus_write(OFS_CTRL, {18'h0, ctrl});
    repeat (10) @(posedge clk);
    pins_u.drive_a(1'b1, 3);
    pins_u.drive_b(1'b1, 1);
    bus_read(OFS_CAP_B, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
